// >>> core/tdic_top.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
module tdic_top
(
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   input  wire logic        slave_mode_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [2:0]  timer_req_in,
   input  wire logic [1:0]  dma_req_in,
   input  wire logic        watchdog_pending_in,
   input  wire logic [4:0]  ext_pending_in,
   input  wire logic        serial_int_enable_in,
   input  wire logic        transmit_empty_source_in,
   input  wire logic        receive_ready_source_in,
   input  wire logic        break_detect_source_in,
   input  wire logic        framing_error_source_in,
   input  wire logic        parity_error_source_in,
   input  wire logic        overrun_error_source_in,
   input  wire logic        nmi_event_in,
   input  wire logic        interrupt_return_instruction_in,
   input  wire logic        int_ack_in,
   output      logic [15:0] reg_rdata_out,
   output      logic        dma_halt_out,
   output      logic [1:0]  dma_pin_is_int_out,
   output      logic [5:0]  mask_dup_out,
   output      logic        irq_valid_out,
   output      logic [2:0]  irq_level_out,
   output      logic [7:0]  irq_vector_out
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // Bus capture and control registers
   // ----------------------------------------------------------------
   tdic_pkg::tdic_bus_t  bus;
   tdic_pkg::tdic_ctrl_t tgrp_r;
   tdic_pkg::tdic_ctrl_t t1_r;
   tdic_pkg::tdic_ctrl_t t2_r;
   tdic_pkg::tdic_ctrl_t dma_r [2];
   logic [1:0]           dma_sel_r;

   assign bus.addr  = reg_addr_in;
   assign bus.wdata = reg_wdata_in;
   assign bus.wr    = reg_wr_in;
   assign bus.rd    = reg_rd_in;

   // Offset 032h is the shared timer control in master mode and the
   // timer 0 control in slave mode; one flop set serves both meanings.
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         tgrp_r <= tdic_pkg::CTRL_RESET;
         t1_r   <= tdic_pkg::CTRL_RESET;
         t2_r   <= tdic_pkg::CTRL_RESET;
      end
      else if (bus.wr)
      begin
         // Only bits 3:0 are stored; reserved bits are expected written as zero.
         case (bus.addr)
            tdic_pkg::OFF_TIMER_GROUP_CTRL: tgrp_r <= bus.wdata[3:0];
            tdic_pkg::OFF_TIMER1_CTRL_SLAVE:
               if (slave_mode_in)
                  t1_r <= bus.wdata[3:0];
            tdic_pkg::OFF_TIMER2_CTRL_SLAVE:
               if (slave_mode_in)
                  t2_r <= bus.wdata[3:0];
            default: ;
         endcase
      end
   end

   // DMA controls: identical in both modes. The extra selector bit (4)
   // chooses interrupt versus DMA request for the shared pin.
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         dma_r[0]  <= tdic_pkg::CTRL_RESET;
         dma_r[1]  <= tdic_pkg::CTRL_RESET;
         dma_sel_r <= 2'h0;
      end
      else if (bus.wr)
      begin
         if (bus.addr == tdic_pkg::OFF_DMA0_EXT5_CTRL)
         begin
            dma_r[0]     <= bus.wdata[3:0];
            dma_sel_r[0] <= bus.wdata[4];
         end
         if (bus.addr == tdic_pkg::OFF_DMA1_EXT6_CTRL)
         begin
            dma_r[1]     <= bus.wdata[3:0];
            dma_sel_r[1] <= bus.wdata[4];
         end
      end
   end

   // ----------------------------------------------------------------
   // Timer pending bits and DMA halt
   // ----------------------------------------------------------------
   logic [2:0] tmr_pend_r;
   logic       halt_r;
   logic       wr_status;
   logic [2:0] tmr_ack;
   logic [1:0] dma_ack;

   assign wr_status = bus.wr && (bus.addr == tdic_pkg::OFF_DMA_HALT_TIMER_PEND);

   // New requests win over a software write or acknowledge in the same cycle.
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         tmr_pend_r <= 3'h0;
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (timer_req_in[i])
               tmr_pend_r[i] <= 1'b1;
            else if (wr_status)
               tmr_pend_r[i] <= bus.wdata[i];
            else if (tmr_ack[i])
               tmr_pend_r[i] <= 1'b0;
         end
      end
   end

   // NMI set beats both software clear and return-from-interrupt clear.
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         halt_r <= 1'b0;
      else if (nmi_event_in)
         halt_r <= 1'b1;
      else if (interrupt_return_instruction_in)
         halt_r <= 1'b0;
      else if (wr_status)
         halt_r <= bus.wdata[tdic_pkg::DMA_HALT_BIT];
   end

   // ----------------------------------------------------------------
   // DMA request latches (both modes)
   // ----------------------------------------------------------------
   logic [1:0] dma_pend_r;

   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         dma_pend_r <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (dma_req_in[i] && dma_sel_r[i] == 1'b0)
               dma_pend_r[i] <= 1'b1;
            else if (dma_ack[i])
               dma_pend_r[i] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Priority resolution
   // ----------------------------------------------------------------
   logic                 pend_v [tdic_pkg::NUM_SOURCES];
   tdic_pkg::tdic_ctrl_t ctrl_v [tdic_pkg::NUM_SOURCES];
   logic [7:0]           vec_v  [tdic_pkg::NUM_SOURCES];
   tdic_pkg::tdic_req_t  best;

   always_comb
   begin
      pend_v[tdic_pkg::SRC_T0] = tmr_pend_r[0];
      pend_v[tdic_pkg::SRC_T1] = tmr_pend_r[1];
      pend_v[tdic_pkg::SRC_T2] = tmr_pend_r[2];
      pend_v[tdic_pkg::SRC_D0] = dma_pend_r[0];
      pend_v[tdic_pkg::SRC_D1] = dma_pend_r[1];
      // Master mode shares one control; slave mode uses one per timer.
      ctrl_v[tdic_pkg::SRC_T0] = tgrp_r;
      ctrl_v[tdic_pkg::SRC_T1] = slave_mode_in ? t1_r : tgrp_r;
      ctrl_v[tdic_pkg::SRC_T2] = slave_mode_in ? t2_r : tgrp_r;
      ctrl_v[tdic_pkg::SRC_D0] = dma_r[0];
      ctrl_v[tdic_pkg::SRC_D1] = dma_r[1];
      vec_v[tdic_pkg::SRC_T0]  = tdic_pkg::VEC_TIMER0;
      vec_v[tdic_pkg::SRC_T1]  = tdic_pkg::VEC_TIMER1;
      vec_v[tdic_pkg::SRC_T2]  = tdic_pkg::VEC_TIMER2;
      vec_v[tdic_pkg::SRC_D0]  = tdic_pkg::VEC_DMA0;
      vec_v[tdic_pkg::SRC_D1]  = tdic_pkg::VEC_DMA1;
   end

   tdic_resolve #(.N(tdic_pkg::NUM_SOURCES)) u_resolve
   (
      .pend_in   (pend_v),
      .ctrl_in   (ctrl_v),
      .vector_in (vec_v),
      .best_out  (best)
   );

   // Acknowledge clears the source currently being offered.
   always_comb
   begin
      tmr_ack = 3'h0;
      dma_ack = 2'h0;
      if (int_ack_in && irq_valid_out)
      begin
         case (irq_vector_out)
            tdic_pkg::VEC_TIMER0: tmr_ack[0] = 1'b1;
            tdic_pkg::VEC_TIMER1: tmr_ack[1] = 1'b1;
            tdic_pkg::VEC_TIMER2: tmr_ack[2] = 1'b1;
            tdic_pkg::VEC_DMA0:   dma_ack[0] = 1'b1;
            tdic_pkg::VEC_DMA1:   dma_ack[1] = 1'b1;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Request views
   // ----------------------------------------------------------------
   logic        serial_or;
   logic [15:0] req_master;
   logic [15:0] req_slave;
   logic [15:0] status_view;
   logic [5:0]  mask_view;

   assign serial_or = serial_int_enable_in &&
                      (transmit_empty_source_in | receive_ready_source_in |
                       break_detect_source_in | framing_error_source_in |
                       parity_error_source_in | overrun_error_source_in);

   always_comb
   begin
      req_master = 16'h0000;
      req_master[tdic_pkg::MSTR_SERIAL_BIT] = serial_or;
      req_master[tdic_pkg::MSTR_WDOG_BIT]   = watchdog_pending_in;
      req_master[tdic_pkg::MSTR_EXT_LO +: 5] = ext_pending_in;
      req_master[tdic_pkg::MSTR_DMA_LO +: 2] = dma_pend_r;
      req_master[0] = |tmr_pend_r;
      req_slave = tdic_pkg::SLV_REQ_RESET;
      req_slave[tdic_pkg::SLV_TIMER2_PENDING_BIT]      = tmr_pend_r[2];
      req_slave[tdic_pkg::SLV_TIMER1_PENDING_BIT]      = tmr_pend_r[1];
      req_slave[tdic_pkg::MSTR_DMA_LO +: 2]  = dma_pend_r;
      req_slave[0]                           = tmr_pend_r[0];
      status_view = 16'h0000;
      status_view[tdic_pkg::DMA_HALT_BIT] = halt_r;
      status_view[2:0] = tmr_pend_r;
      mask_view = {ctrl_v[tdic_pkg::SRC_T2].source_mask_bit,
                   ctrl_v[tdic_pkg::SRC_T1].source_mask_bit,
                   dma_r[1].source_mask_bit,
                   dma_r[0].source_mask_bit,
                   1'b0,
                   tgrp_r.source_mask_bit};
   end

   // ----------------------------------------------------------------
   // Read data and registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
         reg_rdata_out <= 16'h0000;
      else if (bus.rd)
      begin
         case (bus.addr)
            tdic_pkg::OFF_REQUEST_STATUS:
               reg_rdata_out <= slave_mode_in ? req_slave : req_master;
            tdic_pkg::OFF_DMA_HALT_TIMER_PEND: reg_rdata_out <= status_view;
            tdic_pkg::OFF_TIMER_GROUP_CTRL:    reg_rdata_out <= {12'h000, tgrp_r};
            tdic_pkg::OFF_DMA0_EXT5_CTRL:
               reg_rdata_out <= {11'h000, dma_sel_r[0], dma_r[0]};
            tdic_pkg::OFF_DMA1_EXT6_CTRL:
               reg_rdata_out <= {11'h000, dma_sel_r[1], dma_r[1]};
            tdic_pkg::OFF_TIMER1_CTRL_SLAVE:
               reg_rdata_out <= slave_mode_in ? {12'h000, t1_r} : 16'h0000;
            tdic_pkg::OFF_TIMER2_CTRL_SLAVE:
               reg_rdata_out <= slave_mode_in ? {12'h000, t2_r} : 16'h0000;
            default: reg_rdata_out <= 16'h0000;
         endcase
      end
      else
         reg_rdata_out <= 16'h0000;
   end

   always_ff @(posedge mclk_in or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         dma_halt_out       <= 1'b0;
         dma_pin_is_int_out <= 2'h0;
         mask_dup_out       <= 6'h3D;
         irq_valid_out      <= 1'b0;
         irq_level_out      <= 3'h7;
         irq_vector_out     <= 8'h00;
      end
      else
      begin
         dma_halt_out       <= halt_r;
         dma_pin_is_int_out <= dma_sel_r;
         mask_dup_out       <= mask_view;
         irq_valid_out      <= best.valid && !(int_ack_in && irq_valid_out);
         irq_level_out      <= best.level;
         irq_vector_out     <= best.vector;
      end
   end

endmodule

// >>> core/tdic_pkg.sv
package tdic_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses as printed)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_REQUEST_STATUS      = 8'h2E;
   localparam logic [7:0] OFF_DMA_HALT_TIMER_PEND = 8'h30;
   localparam logic [7:0] OFF_TIMER_GROUP_CTRL    = 8'h32;
   localparam logic [7:0] OFF_DMA0_EXT5_CTRL      = 8'h34;
   localparam logic [7:0] OFF_DMA1_EXT6_CTRL      = 8'h36;
   localparam logic [7:0] OFF_TIMER1_CTRL_SLAVE   = 8'h38;
   localparam logic [7:0] OFF_TIMER2_CTRL_SLAVE   = 8'h3A;

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int          MASK_BIT         = 3;
   localparam int          DMA_HALT_BIT     = 15;
   localparam int          MSTR_SERIAL_BIT  = 10;
   localparam int          MSTR_WDOG_BIT    = 9;
   localparam int          MSTR_EXT_LO      = 4;
   localparam int          MSTR_DMA_LO      = 2;
   localparam int          SLV_TIMER2_PENDING_BIT     = 5;
   localparam int          SLV_TIMER1_PENDING_BIT     = 4;
   localparam logic [3:0]  CTRL_RESET       = 4'hF;
   localparam logic [15:0] SLV_REQ_RESET    = 16'h0000;
   localparam int          NUM_SOURCES      = 5;

   // Vector types delivered with each source
   localparam logic [7:0]  VEC_TIMER0       = 8'h08;
   localparam logic [7:0]  VEC_TIMER1       = 8'h12;
   localparam logic [7:0]  VEC_TIMER2       = 8'h13;
   localparam logic [7:0]  VEC_DMA0         = 8'h0A;
   localparam logic [7:0]  VEC_DMA1         = 8'h0B;

   // Source index order for the resolver
   localparam int          SRC_T0 = 0;
   localparam int          SRC_T1 = 1;
   localparam int          SRC_T2 = 2;
   localparam int          SRC_D0 = 3;
   localparam int          SRC_D1 = 4;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        source_mask_bit;
      logic [2:0]  priority_level_field;
   } tdic_ctrl_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  level;
      logic [7:0]  vector;
   } tdic_req_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } tdic_bus_t;

endpackage

// >>> core/tdic_resolve.sv
`timescale 1ns/1ps
module tdic_resolve
#(
   parameter int N = tdic_pkg::NUM_SOURCES
)
(
   input  wire logic                 pend_in   [N],
   input  wire tdic_pkg::tdic_ctrl_t ctrl_in   [N],
   input  wire logic [7:0]           vector_in [N],
   output      tdic_pkg::tdic_req_t  best_out
);

   // ----------------------------------------------------------------
   // Pick the unmasked pending source with the lowest level code
   // ----------------------------------------------------------------
   // Ties go to the lower index, which keeps the choice stable.
   always_comb
   begin
      best_out = '0;
      for (int i = 0; i < N; i++)
      begin
         if (pend_in[i] && !ctrl_in[i].source_mask_bit)
         begin
            if (!best_out.valid || (ctrl_in[i].priority_level_field < best_out.level))
            begin
               best_out.valid  = 1'b1;
               best_out.level  = ctrl_in[i].priority_level_field;
               best_out.vector = vector_in[i];
            end
         end
      end
   end

endmodule

// >>> tb/tdic_monitor.sv
`timescale 1ns/1ps
module tdic_monitor
(
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic        nmi_event_in,
   input  wire logic        interrupt_return_instruction_in,
   input  wire logic [15:0] reg_rdata_out,
   input  wire logic        dma_halt_out,
   input  wire logic [5:0]  mask_dup_out,
   input  wire logic        irq_valid_out,
   input  wire logic [7:0]  irq_vector_out
);
   // ----------------------------------------------------------------
   // Port checks
   // ----------------------------------------------------------------
   logic halt_wr;
   // Combinational qualifier so that $past sees a plain signal
   assign halt_wr = reg_wr_in && reg_addr_in == tdic_pkg::OFF_DMA_HALT_TIMER_PEND
                    && reg_wdata_in[15];
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);
   AST_HALT_SET: assert property (nmi_event_in |-> ##2 dma_halt_out)
      else $error("halt flag not raised after nmi");
   AST_HALT_CLR: assert property (interrupt_return_instruction_in && !nmi_event_in |-> ##2 !dma_halt_out)
      else $error("halt flag not cleared by return");
   AST_HALT_CAUSE: assert property ($rose(dma_halt_out) |-> $past(nmi_event_in, 2) || $past(halt_wr, 2))
      else $error("halt flag rose without cause");
   AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
      else $error("read data outside read slot");
   AST_STS_RSV: assert property (reg_rd_in && reg_addr_in == 8'h30 |=> reg_rdata_out[14:3] == 12'h000)
      else $error("status reserved bits not zero");
   AST_OFFER_UNMASKED: assert property (irq_valid_out |->
      (irq_vector_out == tdic_pkg::VEC_TIMER0 && !mask_dup_out[0]) ||
      (irq_vector_out == tdic_pkg::VEC_TIMER1 && !mask_dup_out[4]) ||
      (irq_vector_out == tdic_pkg::VEC_TIMER2 && !mask_dup_out[5]) ||
      (irq_vector_out == tdic_pkg::VEC_DMA0 && !mask_dup_out[2]) ||
      (irq_vector_out == tdic_pkg::VEC_DMA1 && !mask_dup_out[3]))
      else $error("offered source is masked or vector wrong");
   AST_ALL_MASKED: assert property (mask_dup_out == 6'h3D |-> !irq_valid_out)
      else $error("offer while every source masked");
   AST_MASK_RESET: assert property ($rose(reset_n_in) |-> mask_dup_out == 6'h3D && !irq_valid_out)
      else $error("mask duplicates wrong at reset");
endmodule

bind tdic_top tdic_monitor u_mon (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .nmi_event_in(nmi_event_in),
   .interrupt_return_instruction_in(interrupt_return_instruction_in),
   .reg_rdata_out(reg_rdata_out), .dma_halt_out(dma_halt_out), .mask_dup_out(mask_dup_out),
   .irq_valid_out(irq_valid_out), .irq_vector_out(irq_vector_out));

// >>> tb/tdic_core_model.sv
`timescale 1ns/1ps
module tdic_core_model
(
   input  wire logic       mclk_in,
   input  wire logic       reset_n_in,
   input  wire logic       ack_en_in,
   input  wire logic [3:0] ack_delay_in,
   input  wire logic       irq_valid_in,
   output      logic       int_ack_out
);
   // ----------------------------------------------------------------
   // Core acknowledge
   // ----------------------------------------------------------------
   logic [4:0] wait_r;
   // Two spare cycles: the offer only drops a cycle after the acknowledge
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         wait_r      <= 5'h00;
         int_ack_out <= 1'b0;
      end
      else if (!ack_en_in || !irq_valid_in || int_ack_out)
      begin
         wait_r      <= 5'h00;
         int_ack_out <= 1'b0;
      end
      else
      begin
         wait_r      <= wait_r + 5'h01;
         int_ack_out <= (wait_r == {1'b0, ack_delay_in} + 5'h02);
      end
   end
endmodule

// >>> tb/tdic_top_test.sv
`timescale 1ns/1ps
module tdic_top_test;
   // ----------------------------------------------------------------
   // Stimulus and checks
   // ----------------------------------------------------------------
   logic        clk, rst_n, slv, wr_s, rd_s, wd, ser_en, ack_en, ack, halt, ivalid;
   logic [7:0]  addr, ivec;
   logic [15:0] wdata, rdata;
   logic [6:0]  ev;
   logic [4:0]  ext;
   logic [5:0]  ser_src, mdup;
   logic [3:0]  ack_dly;
   logic [1:0]  pin;
   logic [2:0]  ilvl;
   int          n_fail = 0;
   int          tests_run = 0;

   tdic_top DUT (.mclk_in(clk), .reset_n_in(rst_n), .slave_mode_in(slv), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .timer_req_in(ev[2:0]),
      .dma_req_in(ev[4:3]), .watchdog_pending_in(wd), .ext_pending_in(ext),
      .serial_int_enable_in(ser_en), .transmit_empty_source_in(ser_src[0]),
      .receive_ready_source_in(ser_src[1]), .break_detect_source_in(ser_src[2]),
      .framing_error_source_in(ser_src[3]), .parity_error_source_in(ser_src[4]),
      .overrun_error_source_in(ser_src[5]), .nmi_event_in(ev[5]),
      .interrupt_return_instruction_in(ev[6]), .int_ack_in(ack), .reg_rdata_out(rdata),
      .dma_halt_out(halt), .dma_pin_is_int_out(pin), .mask_dup_out(mdup),
      .irq_valid_out(ivalid), .irq_level_out(ilvl), .irq_vector_out(ivec));
   tdic_core_model u_core (.mclk_in(clk), .reset_n_in(rst_n), .ack_en_in(ack_en),
      .ack_delay_in(ack_dly), .irq_valid_in(ivalid), .int_ack_out(ack));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task conclude;
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic do_reset(input logic s);
      @(posedge clk);
      rst_n <= 1'b0;
      slv   <= s;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk("rdata", rdata, e);
   endtask

   // Timer bits 2:0, DMA 4:3, nmi 5, return 6
   task automatic pulse(input logic [6:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 7'h00;
   endtask

   task automatic wait_irq(input logic [7:0] v, input logic [2:0] l);
      int i;
      for (i = 0; i < 40 && !(ivalid === 1'b1 && ivec === v); i++)
         @(negedge clk);
      chk("vector", {8'h00, ivec}, {8'h00, v});
      chk("level", {13'h0000, ilvl}, {13'h0000, l});
      if (i == 40)
      begin
         n_fail++;
         conclude();
      end
   endtask

   task automatic drain;
      @(posedge clk);
      ack_en <= 1'b1;
      repeat (30) @(posedge clk);
      ack_en <= 1'b0;
   endtask

   initial
   begin
      {rst_n, slv, wr_s, rd_s, wd, ser_en, ack_en} = 7'h00;
      {addr, wdata, ev, ext, ser_src, ack_dly} = 46'h0;
      do_reset(1'b0);
      rd(8'h2E, 16'h0000);
      rd(8'h30, 16'h0000);
      rd(8'h32, 16'h000F);
      rd(8'h34, 16'h000F);
      rd(8'h36, 16'h000F);
      rd(8'h40, 16'h0000);
      chk("mask_dup", {10'h000, mdup}, 16'h003D);
      wr(8'h38, 16'h0001);
      rd(8'h38, 16'h0000);
      @(posedge clk);
      wd      <= 1'b1;
      ext     <= 5'h15;
      ser_src <= 6'h20;
      rd(8'h2E, 16'h0350);
      for (int k = 0; k < 6; k++)
      begin
         @(posedge clk);
         ser_en  <= 1'b1;
         ser_src <= 6'(1 << k);
         rd(8'h2E, 16'h0750);
      end
      @(posedge clk);
      {wd, ext, ser_en} <= 7'h00;
      wr(8'h34, 16'h0003);
      for (int lv = 0; lv < 8; lv++)
      begin
         wr(8'h32, 16'(lv));
         ack_dly <= 4'(lv);
         pulse(7'h09);
         rd(8'h2E, 16'h0005);
         wait_irq(lv <= 3 ? tdic_pkg::VEC_TIMER0 : tdic_pkg::VEC_DMA0, lv <= 3 ? 3'(lv) : 3'h3);
         drain();
         rd(8'h30, 16'h0000);
      end
      wr(8'h32, 16'h000A);
      pulse(7'h02);
      rd(8'h30, 16'h0002);
      chk("irq_valid", {15'h0000, ivalid}, 16'h0000);
      chk("mask_dup", {10'h000, mdup}, 16'h0039);
      wr(8'h32, 16'h0004);
      wait_irq(tdic_pkg::VEC_TIMER1, 3'h4);
      drain();
      rd(8'h30, 16'h0000);
      wr(8'h34, 16'h0013);
      pulse(7'h08);
      chk("pin_sel", {14'h0000, pin}, 16'h0001);
      rd(8'h2E, 16'h0000);
      wr(8'h32, 16'h000C);
      pulse(7'h20);
      rd(8'h30, 16'h8000);
      chk("halt", {15'h0000, halt}, 16'h0001);
      pulse(7'h60);
      rd(8'h30, 16'h8000);
      pulse(7'h40);
      rd(8'h30, 16'h0000);
      wr(8'h30, 16'h8000);
      rd(8'h30, 16'h8000);
      wr(8'h30, 16'h0000);
      rd(8'h30, 16'h0000);
      do_reset(1'b1);
      rd(8'h2E, 16'h0000);
      rd(8'h38, 16'h000F);
      rd(8'h3A, 16'h000F);
      rd(8'h34, 16'h000F);
      wr(8'h38, 16'h0001);
      wr(8'h3A, 16'h0003);
      wr(8'h32, 16'h0005);
      rd(8'h3A, 16'h0003);
      chk("mask_dup", {10'h000, mdup}, 16'h000C);
      pulse(7'h16);
      rd(8'h2E, 16'h0038);
      wait_irq(tdic_pkg::VEC_TIMER1, 3'h1);
      drain();
      rd(8'h2E, 16'h0008);
      wr(8'h36, 16'h0002);
      wait_irq(tdic_pkg::VEC_DMA1, 3'h2);
      drain();
      wr(8'h2E, 16'hFFFF);
      rd(8'h2E, 16'h0000);
      conclude();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      conclude();
   end
endmodule
